// *** design/timer_pkg.sv ***
// shared constants and state types for the timer channel block
package timer_pkg;

  // geometry
  localparam int NUM_CH  = 4;
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int STRB_W  = 4;
  localparam int REG_W   = 16;
  localparam int IDX_W   = 2;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = IDX_LSB + IDX_W - 1;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] DATA_BASE  = 32'h4000_0000;
  localparam logic [ADDR_W-1:0] COUNT_BASE = 32'h4000_0040;
  localparam logic [ADDR_W-1:0] MODE_BASE  = 32'h4000_0080;
  localparam logic [ADDR_W-1:0] RUN_ADDR   = 32'h4000_00C0;
  localparam logic [ADDR_W-1:0] BLOCK_MASK = 32'hFFFF_FFF0;

  // channel_mode_control layout
  localparam int PRESC_SEL_HI   = 15;
  localparam int PRESC_SEL_LO   = 14;
  localparam int CNT_CLK_SEL_HI = 13;
  localparam int CNT_CLK_SEL_LO = 12;
  localparam int MASTER_ROLE    = 11;
  localparam int START_TRIG_HI  = 10;
  localparam int START_TRIG_LO  = 8;
  localparam int OP_MODE_HI     = 4;
  localparam int OP_MODE_LO     = 1;
  localparam int ZERO_BIT       = 5;
  localparam logic [REG_W-1:0]  MODE_RESET = 16'h0000;
  localparam logic [REG_W-1:0]  MODE_MASK  = 16'hFFDF;
  localparam logic [STRB_W-1:0] STRB_HALF  = 4'h3;

  // count clock select codes
  localparam logic [1:0] CCLK_PRESCALER = 2'h0;
  localparam logic [1:0] CCLK_EVENT     = 2'h1;

  // start trigger select codes
  localparam logic [2:0] TRIG_SOFT   = 3'h0;
  localparam logic [2:0] TRIG_EDGE   = 3'h1;
  localparam logic [2:0] TRIG_MASTER = 3'h4;

  // operating mode codes (upper four bits of the mode field)
  localparam logic [3:0] MD_INTERVAL      = 4'h0;
  localparam logic [3:0] MD_PULSE_MEAS    = 4'h2;
  localparam logic [3:0] MD_TRIG_INTERVAL = 4'h3;
  localparam logic [3:0] MD_EVENT_COUNT   = 4'h4;
  localparam logic [3:0] MD_DELAY         = 4'h5;
  localparam logic [3:0] MD_WIDTH_MEAS    = 4'h6;
  localparam logic [3:0] MD_PWM_DUTY      = 4'h9;

  // prescaler: output k ticks when the low bits below tap k are all ones
  localparam int PRESC_W  = 8;
  localparam int PRESC_T1 = 2;
  localparam int PRESC_T2 = 4;
  localparam int PRESC_T3 = 8;

  localparam logic [REG_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [REG_W-1:0] CNT_ONE  = 16'h0001;

  typedef enum logic {PH_IDLE, PH_ARMED} phase_t;

  typedef struct packed {
    logic [REG_W-1:0] count;
    logic [REG_W-1:0] data;
    phase_t           phase;
    logic             irq;
    logic             pwm;
    logic             tick_out;
  } chan_state_t;

  typedef struct packed {
    logic                         pready;
    logic                         pslverr;
    logic [DATA_W-1:0]            prdata;
    logic [NUM_CH-1:0][REG_W-1:0] mode;
    logic [NUM_CH-1:0]            run;
    logic [NUM_CH-1:0]            run_prev;
    logic [NUM_CH-1:0]            ev_prev;
    logic [PRESC_W-1:0]           presc;
  } top_state_t;

  localparam chan_state_t CHAN_RESET = '0;
  // every mode register clears to MODE_RESET, i.e. all zeros
  localparam top_state_t  TOP_RESET  = '0;

endpackage

// *** design/timer_chan_if.sv ***
// link between the register/prescaler side and one timer channel
`timescale 1ns/100ps
interface timer_chan_if;
  import timer_pkg::*;
  logic [3:0]       op_mode;
  logic             master;
  logic             run;
  logic             start;
  logic             trig;
  logic             cnt_tick;
  logic             rise;
  logic             fall;
  logic             data_wr;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] count;
  logic [REG_W-1:0] data;
  logic             irq;
  logic             pwm;
  logic             tick_out;

  modport ctrl (output op_mode, master, run, start, trig, cnt_tick, rise, fall,
                output data_wr, wdata,
                input  count, data, irq, pwm, tick_out);
  modport chan (input  op_mode, master, run, start, trig, cnt_tick, rise, fall,
                input  data_wr, wdata,
                output count, data, irq, pwm, tick_out);
endinterface

// *** design/timer_channel.sv ***
// one timer channel: counter, data register and mode sequencing
`timescale 1ns/100ps
module timer_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control side
  timer_chan_if.chan ch
);
  import timer_pkg::*;

  chan_state_t s;
  chan_state_t next_s;

  always_comb begin
    next_s          = s;
    next_s.irq      = 1'b0;
    next_s.tick_out = 1'b0;
    if (ch.data_wr) begin
      next_s.data = ch.wdata;
    end
    if (!ch.run) begin
      next_s.phase = PH_IDLE;
      next_s.pwm   = 1'b0;
    end else begin
      case (ch.op_mode)
        MD_INTERVAL, MD_TRIG_INTERVAL: begin
          if (ch.start) begin
            next_s.count = s.data;
          end else if ((ch.op_mode == MD_TRIG_INTERVAL && ch.rise) ||
                       (ch.cnt_tick && s.count == CNT_ZERO)) begin
            next_s.irq      = 1'b1;
            next_s.tick_out = ch.master;
            next_s.count    = s.data;
          end else if (ch.cnt_tick) begin
            next_s.count = s.count - CNT_ONE;
          end
        end
        MD_DELAY, MD_PWM_DUTY: begin
          // a new trigger always restarts the delay, except in pwm duty mode with data zero, where it leaves the channel idle
          if (ch.trig) begin
            if (ch.op_mode == MD_PWM_DUTY) begin
              next_s.count = s.data - CNT_ONE;
              next_s.pwm   = (s.data != CNT_ZERO);
              next_s.phase = (s.data != CNT_ZERO) ? PH_ARMED : PH_IDLE;
            end else begin
              next_s.count = s.data;
              next_s.phase = PH_ARMED;
            end
          end else if (s.phase == PH_ARMED && ch.cnt_tick) begin
            if (s.count == CNT_ZERO) begin
              next_s.irq   = 1'b1;
              next_s.pwm   = 1'b0;
              next_s.phase = PH_IDLE;
            end else begin
              next_s.count = s.count - CNT_ONE;
            end
          end
        end
        MD_PULSE_MEAS: begin
          // the counter wraps on long intervals; no overflow flag is kept
          if (ch.start) begin
            next_s.count = CNT_ZERO;
          end else if (ch.rise) begin
            // the tick of the capture cycle already belongs to the next interval
            next_s.data  = s.count;
            next_s.irq   = 1'b1;
            next_s.count = ch.cnt_tick ? CNT_ONE : CNT_ZERO;
          end else if (ch.cnt_tick) begin
            next_s.count = s.count + CNT_ONE;
          end
        end
        MD_WIDTH_MEAS: begin
          if (ch.rise) begin
            next_s.count = ch.cnt_tick ? CNT_ONE : CNT_ZERO;
            next_s.phase = PH_ARMED;
          end else if (ch.fall && s.phase == PH_ARMED) begin
            next_s.data  = s.count;
            next_s.irq   = 1'b1;
            next_s.phase = PH_IDLE;
          end else if (ch.cnt_tick && s.phase == PH_ARMED) begin
            next_s.count = s.count + CNT_ONE;
          end
        end
        MD_EVENT_COUNT: begin
          if (ch.start) begin
            next_s.count = s.data;
          end else if (ch.rise) begin
            if (s.count <= CNT_ONE) begin
              next_s.irq   = 1'b1;
              next_s.count = s.data;
            end else begin
              next_s.count = s.count - CNT_ONE;
            end
          end
        end
        default: begin
          next_s.phase = PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= CHAN_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign ch.count    = s.count;
  assign ch.data     = s.data;
  assign ch.irq      = s.irq;
  assign ch.pwm      = s.pwm;
  assign ch.tick_out = s.tick_out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_INTERVAL_FIRE: assert property (
    ch.run && ch.op_mode == MD_INTERVAL && !ch.start && ch.cnt_tick &&
    s.count == CNT_ZERO |=> ch.irq && s.count == $past(s.data))
    else $error("interval channel missed its period interrupt");
  AST_TRIG_EDGE_FIRE: assert property (
    ch.run && ch.op_mode == MD_TRIG_INTERVAL && !ch.start && ch.rise |=> ch.irq)
    else $error("input edge did not raise the interval interrupt");
  AST_DELAY_ONLY_ARMED: assert property (
    ch.irq && $past(ch.run && ch.op_mode == MD_DELAY) |-> $past(s.phase == PH_ARMED))
    else $error("delay interrupt without a preceding trigger");
  AST_PULSE_CAPTURE: assert property (
    ch.run && ch.op_mode == MD_PULSE_MEAS && !ch.start && ch.rise
    |=> ch.irq && s.data == $past(s.count) &&
        s.count == ($past(ch.cnt_tick) ? CNT_ONE : CNT_ZERO))
    else $error("pulse interval not captured on edge");
  AST_WIDTH_CAPTURE: assert property (
    ch.run && ch.op_mode == MD_WIDTH_MEAS && ch.fall && !ch.rise && s.phase == PH_ARMED
    |=> ch.irq && s.data == $past(s.count) && s.phase == PH_IDLE)
    else $error("signal width not captured at end of active level");
  AST_EVENT_TERMINAL: assert property (
    ch.run && ch.op_mode == MD_EVENT_COUNT && !ch.start && ch.rise && s.count <= CNT_ONE
    |=> ch.irq && s.count == $past(s.data))
    else $error("event count did not interrupt at terminal edge");
  AST_PWM_END: assert property (
    $fell(ch.pwm) && $past(ch.run && ch.op_mode == MD_PWM_DUTY && !ch.trig) |-> ch.irq)
    else $error("pwm pulse ended without duty completion");
  AST_MASTER_TICK: assert property (
    ch.tick_out |-> $past(ch.master) && ch.irq)
    else $error("period tick sent by a slave channel");

  COV_INTERVAL: cover property (ch.run && ch.op_mode == MD_INTERVAL ##1 ch.irq);
  COV_PWM: cover property ($rose(ch.pwm) ##[1:300] $fell(ch.pwm));
  COV_CAPTURE: cover property (ch.op_mode == MD_WIDTH_MEAS && ch.irq);

endmodule

// *** design/timer_channel_functions.sv ***
// timer channel unit: apb register file, prescaler, trigger routing, channels
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
// Notes on behaviour
// - in interval mode a channel interrupts every time its count reaches zero and reloads.
// - in triggered interval mode an input edge also interrupts and restarts the period.
// - in delay mode the interrupt comes only after the programmed delay after a trigger.
// - pulse interval mode captures the time between rising input edges.
// - width mode captures how long the input stays high.
// - event count mode interrupts after the programmed number of input edges.
// - a master channel sets the period and a slave channel drives the pwm pulse.
// - the mode register takes only 16-bit writes.
// - the mode register is writable only while its channel is stopped.
// - mode registers sit at base plus four times the channel and reset to zero.
module timer_channel_functions (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [timer_pkg::DATA_W-1:0]     pwdata,
  input  wire logic [timer_pkg::STRB_W-1:0]     pstrb,
  output logic      [timer_pkg::DATA_W-1:0]     prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // timer pins
  input  wire logic [timer_pkg::NUM_CH-1:0]     timer_event_input,
  output logic      [timer_pkg::NUM_CH-1:0]     timer_irq,
  output logic      [timer_pkg::NUM_CH-1:0]     pwm_out
);
  import timer_pkg::*;

  top_state_t s;
  top_state_t next_s;

  logic                         setup;
  logic                         access;
  logic                         commit;
  logic [IDX_W-1:0]             idx;
  logic [ADDR_W-1:0]            blk;
  logic [3:0]                   ptick;
  logic [NUM_CH-1:0]            rise;
  logic [NUM_CH-1:0]            fall;
  logic [NUM_CH-1:0]            start;
  logic [NUM_CH-1:0]            cnt_tick;
  logic [NUM_CH-1:0]            mtick;
  logic [NUM_CH-1:0]            ch_tick;
  logic [NUM_CH-1:0][REG_W-1:0] ch_data;
  logic [NUM_CH-1:0][REG_W-1:0] ch_count;

  assign setup  = psel && !penable;
  // answer is prepared at setup, so the access phase always completes at once
  assign access = psel && penable && s.pready;
  assign commit = access && pwrite && !s.pslverr;
  assign idx    = paddr[IDX_MSB:IDX_LSB];
  assign blk    = paddr & BLOCK_MASK;

  // prescaler taps, output zero runs at the full clock rate
  assign ptick[0] = 1'b1;
  assign ptick[1] = &s.presc[PRESC_T1-1:0];
  assign ptick[2] = &s.presc[PRESC_T2-1:0];
  assign ptick[3] = &s.presc[PRESC_T3-1:0];

  assign rise  = timer_event_input & ~s.ev_prev;
  assign fall  = ~timer_event_input & s.ev_prev;
  assign start = s.run & ~s.run_prev;

  timer_chan_if chan_if [NUM_CH] ();

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [1:0] presc_sel;
    logic [1:0] clk_sel;
    logic [2:0] trig_sel;

    assign presc_sel = s.mode[i][PRESC_SEL_HI:PRESC_SEL_LO];
    assign clk_sel   = s.mode[i][CNT_CLK_SEL_HI:CNT_CLK_SEL_LO];
    assign trig_sel  = s.mode[i][START_TRIG_HI:START_TRIG_LO];

    // prohibited clock codes leave the channel without a count clock
    assign cnt_tick[i] = (clk_sel == CCLK_PRESCALER) ? ptick[presc_sel] :
                         (clk_sel == CCLK_EVENT)     ? rise[i] : 1'b0;

    // a slave follows the period tick of the channel just below it
    if (i == 0) begin : g_first
      assign mtick[i] = 1'b0;
    end else begin : g_chain
      assign mtick[i] = ch_tick[i-1];
    end

    assign chan_if[i].op_mode  = s.mode[i][OP_MODE_HI:OP_MODE_LO];
    assign chan_if[i].master   = s.mode[i][MASTER_ROLE];
    assign chan_if[i].run      = s.run[i];
    assign chan_if[i].start    = start[i];
    assign chan_if[i].trig     = (trig_sel == TRIG_EDGE)   ? rise[i] :
                                 (trig_sel == TRIG_MASTER) ? mtick[i] :
                                 (trig_sel == TRIG_SOFT)   ? start[i] : 1'b0;
    assign chan_if[i].cnt_tick = cnt_tick[i];
    assign chan_if[i].rise     = rise[i];
    assign chan_if[i].fall     = fall[i];
    assign chan_if[i].data_wr  = commit && blk == DATA_BASE && idx == IDX_W'(i);
    assign chan_if[i].wdata    = pwdata[REG_W-1:0];

    assign ch_data[i]   = chan_if[i].data;
    assign ch_count[i]  = chan_if[i].count;
    assign ch_tick[i]   = chan_if[i].tick_out;
    assign timer_irq[i] = chan_if[i].irq;
    assign pwm_out[i]   = chan_if[i].pwm;

    timer_channel u_chan (
      .clk   (clk),
      .rst_n (rst_n),
      .ch    (chan_if[i])
    );

    AST_CLOCK_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_tick[i] && clk_sel == CCLK_PRESCALER |->
        ptick[presc_sel] && (presc_sel != 2'h3 || &s.presc[PRESC_T3-1:0]))
      else $error("count clock does not follow the prescaler select");
  end

  always_comb begin
    next_s          = s;
    next_s.pready   = 1'b0;
    next_s.pslverr  = 1'b0;
    next_s.presc    = s.presc + PRESC_W'(1);
    next_s.run_prev = s.run;
    next_s.ev_prev  = timer_event_input;
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      case (blk)
        DATA_BASE: begin
          next_s.prdata[REG_W-1:0] = ch_data[idx];
        end
        COUNT_BASE: begin
          next_s.prdata[REG_W-1:0] = ch_count[idx];
          next_s.pslverr           = pwrite;
        end
        MODE_BASE: begin
          next_s.prdata[REG_W-1:0] = s.mode[idx] & MODE_MASK;
          // running channel or a non-halfword write is refused
          next_s.pslverr = pwrite && (s.run[idx] || pstrb != STRB_HALF);
        end
        RUN_ADDR: begin
          next_s.prdata[NUM_CH-1:0] = s.run;
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (commit) begin
      case (blk)
        MODE_BASE: begin
          next_s.mode[idx] = pwdata[REG_W-1:0] & MODE_MASK;
        end
        RUN_ADDR: begin
          next_s.run = pwdata[NUM_CH-1:0];
        end
        default: begin
          next_s.run = s.run;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_APB_ANSWER: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer not given in the access cycle");
  AST_HALFWORD_ONLY: assert property (
    setup && pwrite && blk == MODE_BASE && pstrb != STRB_HALF |=> pready && pslverr)
    else $error("non-halfword mode write was not refused");
  AST_MODE_LOCKED: assert property (
    access && pwrite && blk == MODE_BASE && s.run[idx] |=> $stable(s.mode))
    else $error("mode register changed while channel was running");
  AST_MODE_RESET: assert property (
    !$past(rst_n) |-> s.mode == '0)
    else $error("mode registers not cleared by reset");
  AST_MODE_READ: assert property (
    setup && !pwrite && blk == MODE_BASE
    |=> prdata[REG_W-1:0] == (s.mode[$past(idx)] & MODE_MASK) && !pslverr)
    else $error("mode register read at wrong address");
  AST_BIT5_ZERO: assert property (
    pready && !s.pslverr && blk == MODE_BASE |-> !prdata[ZERO_BIT])
    else $error("reserved mode bit read as one");

  COV_REFUSED: cover property (access && pwrite && blk == MODE_BASE && pslverr);

endmodule

// *** tb/timer_event_source.sv ***
// far-side model: external event pulses per channel and interrupt pulse counters
`timescale 1ns/100ps
module timer_event_source (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // pulse requests from the bench
  input  wire logic [3:0]             go,
  // pins of the timer unit
  input  wire logic [3:0]             timer_irq,
  output logic      [3:0]             timer_event_input,
  // observed interrupt counts
  output logic      [3:0][15:0]       irq_cnt
);
  logic [3:0][2:0] left;

  // high for two cycles, then low for at least two, so every edge is well spaced
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      timer_event_input[i] = left[i][2] | (left[i] == 3'h3);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left    <= '0;
      irq_cnt <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (go[i] && left[i] == 3'h0) begin
          left[i] <= 3'h4;
        end else if (left[i] != 3'h0) begin
          left[i] <= left[i] - 3'h1;
        end
        if (timer_irq[i] === 1'b1) begin
          irq_cnt[i] <= irq_cnt[i] + 16'h1;
        end
      end
    end
  end
endmodule

// *** tb/timer_channel_functions_tb.sv ***
// self-checking bench for the timer channel unit over apb
`timescale 1ns/100ps
module timer_channel_functions_tb;
  import timer_pkg::*;
  logic                   clk;
  logic                   rst_n;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [ADDR_W-1:0]      paddr;
  logic [DATA_W-1:0]      pwdata;
  logic [STRB_W-1:0]      pstrb;
  logic [DATA_W-1:0]      prdata;
  logic                   pready;
  logic                   pslverr;
  logic [NUM_CH-1:0]      timer_event_input;
  logic [NUM_CH-1:0]      timer_irq;
  logic [NUM_CH-1:0]      pwm_out;
  logic [3:0]             go;
  logic [3:0][15:0]       irq_cnt;
  logic [3:0][15:0]       base;
  int                     err_count;
  int                     n_tests;
  int                     n;

  timer_channel_functions u_timer_channel_functions (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_event_input(timer_event_input), .timer_irq(timer_irq),
    .pwm_out(pwm_out));

  timer_event_source u_timer_event_source (
    .clk(clk), .rst_n(rst_n), .go(go), .timer_irq(timer_irq),
    .timer_event_input(timer_event_input), .irq_cnt(irq_cnt));

  always #4 clk = ~clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // one apb transfer; the request is held until pready is seen high
  task automatic apb(input logic wr_en, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd_d, output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_d    = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
    check_flag(e, exp_err, "write error flag");
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
    check_flag(e, exp_err, "read error flag");
    if (!exp_err) begin
      check_val(r, exp, "read data");
    end
  endtask

  task automatic wait_irq0();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timer_irq[0] !== 1'b1 && n < 50);
    check_flag(timer_irq[0], 1'b1, "interrupt seen before limit");
  endtask

  task automatic pulse(input logic [3:0] which);
    go <= which;
    @(posedge clk);
    go <= 4'h0;
    repeat (6) @(posedge clk);
  endtask

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = '0; go = '0;
    err_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      rd(MODE_BASE + 32'(4 * m), 32'h0000_0000, 1'b0);
    end
    wr(MODE_BASE + 32'h4, 32'h0000_FFFF, STRB_HALF, 1'b0);
    rd(MODE_BASE + 32'h4, 32'h0000_FFDF, 1'b0);
    rd(MODE_BASE + 32'h8, 32'h0000_0000, 1'b0);
    wr(MODE_BASE + 32'h4, 32'h0000_0000, 4'hF, 1'b1);
    rd(MODE_BASE + 32'h4, 32'h0000_FFDF, 1'b0);
    rd(32'h4000_0100, 32'h0000_0000, 1'b1);
    $display("test registers done");
    // ch0 interval, ch1 triggered interval, ch2 event count, ch3 delay
    wr(DATA_BASE,         32'h0000_0003, STRB_HALF, 1'b0);
    wr(DATA_BASE + 32'h4, 32'h0000_0064, STRB_HALF, 1'b0);
    wr(DATA_BASE + 32'h8, 32'h0000_0003, STRB_HALF, 1'b0);
    wr(DATA_BASE + 32'hC, 32'h0000_0002, STRB_HALF, 1'b0);
    wr(MODE_BASE,         32'h0000_0000, STRB_HALF, 1'b0);
    wr(MODE_BASE + 32'h4, 32'h0000_0106, STRB_HALF, 1'b0);
    wr(MODE_BASE + 32'h8, 32'h0000_1008, STRB_HALF, 1'b0);
    wr(MODE_BASE + 32'hC, 32'h0000_010A, STRB_HALF, 1'b0);
    wr(RUN_ADDR, 32'h0000_000F, 4'hF, 1'b0);
    wait_irq0();
    wait_irq0();
    check_val(32'(n), 32'h4, "interval period");
    base = irq_cnt;
    go <= 4'hE;
    @(posedge clk);
    go <= 4'h0;
    repeat (2) @(posedge clk);
    check_val({16'h0, irq_cnt[3]}, {16'h0, base[3]}, "delay not yet due");
    repeat (12) @(posedge clk);
    check_val({16'h0, irq_cnt[3]}, {16'h0, base[3] + 16'h1}, "delay irq");
    check_val({16'h0, irq_cnt[1]}, {16'h0, base[1] + 16'h1}, "edge irq");
    check_val({16'h0, irq_cnt[2]}, {16'h0, base[2]}, "one edge of three");
    pulse(4'h4);
    pulse(4'h4);
    check_val({16'h0, irq_cnt[2]}, {16'h0, base[2] + 16'h1}, "event count irq");
    $display("test channel functions done");
    wr(MODE_BASE, 32'h0000_4000, STRB_HALF, 1'b1);
    rd(MODE_BASE, 32'h0000_0000, 1'b0);
    wr(RUN_ADDR, 32'h0000_0000, 4'hF, 1'b0);
    wr(MODE_BASE, 32'h0000_4000, STRB_HALF, 1'b0);
    rd(MODE_BASE, 32'h0000_4000, 1'b0);
    $display("test write while running done");
    // ch0 pwm master on prescaler 1, ch1 pwm duty, ch2 pulse interval, ch3 width
    wr(DATA_BASE,         32'h0000_0004, STRB_HALF, 1'b0);
    wr(DATA_BASE + 32'h4, 32'h0000_0002, STRB_HALF, 1'b0);
    wr(DATA_BASE + 32'hC, 32'h0000_0000, STRB_HALF, 1'b0);
    wr(MODE_BASE,         32'h0000_4800, STRB_HALF, 1'b0);
    wr(MODE_BASE + 32'h4, 32'h0000_0412, STRB_HALF, 1'b0);
    wr(MODE_BASE + 32'h8, 32'h0000_0004, STRB_HALF, 1'b0);
    wr(MODE_BASE + 32'hC, 32'h0000_000C, STRB_HALF, 1'b0);
    wr(RUN_ADDR, 32'h0000_000F, 4'hF, 1'b0);
    rd(RUN_ADDR, 32'h0000_000F, 1'b0);
    wait_irq0();
    wait_irq0();
    // five ticks of a tap that fires every fourth clock
    check_val(32'(n), 32'h14, "prescaled period");
    n = 0;
    while (pwm_out[1] !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (pwm_out[1] === 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check_val(32'(n), 32'h2, "pwm duty width");
    // pulses start seven clocks apart and stay high for two
    pulse(4'hC);
    pulse(4'hC);
    rd(DATA_BASE + 32'h8, 32'h0000_0007, 1'b0);
    rd(DATA_BASE + 32'hC, 32'h0000_0002, 1'b0);
    $display("test pwm and measurement done");
    report_and_stop();
  end
endmodule
